// >>> rsp_checker.sv
// module: query checker, exception builder and protocol switch
module rsp_checker #(
  parameter int  CHAR_CYCLES  = 229167,
  parameter int  IDLE_CYCLES  = rsp_pkg::IDLE_TIMEOUT_S * rsp_pkg::CLK_HZ,
  parameter int  PT_LIMIT     = 2048,
  parameter int  REG_LIMIT    = 1024,
  parameter int  AI_LIMIT     = 64,
  parameter int  SP_TOP       = 255
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_err,
  input  wire logic        rx_break,
  input  wire logic        frame_end,
  input  wire logic        crc_ok,
  input  wire logic        len_short,
  input  wire logic [7:0]  q_addr,
  input  wire logic [7:0]  q_func,
  input  wire logic [15:0] q_start,
  input  wire logic [15:0] q_count,
  input  wire logic [15:0] q_data,
  input  wire logic        core_fail,
  input  wire logic        prog_attach,
  input  wire logic        new_cfg,
  input  wire logic        dg_establish,
  input  wire logic        dg_cancel,
  input  wire logic        tx_ready,
  output logic             tx_valid,
  output logic [7:0]       tx_byte,
  output logic             frame_ok,
  output logic             frame_drop,
  output logic             prog_active,
  output logic             port_quiet,
  output logic             apply_new_cfg,
  output logic             dg_granted,
  output logic             dg_denied,
  output logic [5:0]       dg_count
);
  import rsp_pkg::*;

  // ********************************************************
  // parameter checks
  // ********************************************************
  // limits are compared as 16-bit point and register numbers
  if (CHAR_CYCLES < 1 || IDLE_CYCLES < 2 || SP_TOP > 65535
      || PT_LIMIT < 1 || PT_LIMIT > 65535 || REG_LIMIT < 1
      || REG_LIMIT > 65535 || AI_LIMIT < 1
      || AI_LIMIT > 65535) begin : g_param_check
    $error("rsp_checker: unsupported parameter values");
  end

  // ********************************************************
  // pin synchronisers (rx lines arrive from the uart pins)
  // ********************************************************
  logic [1:0] brk_sync;
  logic [1:0] err_sync;
  always_ff @(posedge mclk) begin
    if (rst) begin
      brk_sync <= 2'h0;
      err_sync <= 2'h0;
    end else if (clk_en) begin
      brk_sync <= {brk_sync[0], rx_break};
      err_sync <= {err_sync[0], rx_err};
    end
  end

  // ********************************************************
  // frame gap timer and error latch
  // ********************************************************
  logic [$clog2(GAP_CHARS*CHAR_CYCLES+1)-1:0] gap_cnt;
  logic in_frame;
  logic bad_seen;
  logic gap_hit;
  assign gap_hit = in_frame
                   && (gap_cnt == ($bits(gap_cnt))'(GAP_CHARS*CHAR_CYCLES));

  always_ff @(posedge mclk) begin
    if (rst) begin
      gap_cnt  <= '0;
      in_frame <= 1'b0;
    end else if (clk_en) begin
      if (rx_valid) begin
        in_frame <= 1'b1;
        gap_cnt  <= '0;
      end else if (gap_hit || frame_end) begin
        in_frame <= 1'b0;
        gap_cnt  <= '0;
      end else if (in_frame) begin
        gap_cnt <= gap_cnt + 1'b1;
      end
    end
  end

  // set wins over the end-of-frame clear
  // errors lag two cycles in the synchroniser; a late one spoils the next frame
  always_ff @(posedge mclk) begin
    if (rst)
      bad_seen <= 1'b0;
    else if (clk_en) begin
      if (err_sync[1])
        bad_seen <= 1'b1;
      else if (frame_end || gap_hit)
        bad_seen <= 1'b0;
    end
  end

  // ********************************************************
  // query classification
  // ********************************************************
  logic [7:0]  next_sub;
  logic [16:0] span;
  assign span = {1'b0, q_start} + {1'b0, q_count};

  always_comb begin
    next_sub = 8'h00;
    unique case (q_func)
      FN_READ_OUT, FN_READ_IN, FN_FORCE_MANY:
        if (span > 17'(PT_LIMIT)) next_sub = SUB_BAD_ADDR;
      FN_READ_REG, FN_WRITE_MANY:
        if (span > 17'(REG_LIMIT)) next_sub = SUB_BAD_ADDR;
      FN_READ_AI:
        if (span > 17'(AI_LIMIT)) next_sub = SUB_BAD_ADDR;
      FN_FORCE_ONE:
        if (q_start >= 16'(PT_LIMIT)) next_sub = SUB_BAD_ADDR;
        else if ((q_data[15:8] != 8'h00 && q_data[15:8] != DATA_ON)
                 || q_data[7:0] != 8'h00)
          next_sub = SUB_BAD_DATA;
      FN_WRITE_ONE:
        if (q_start >= 16'(REG_LIMIT)) next_sub = SUB_BAD_ADDR;
      FN_DIAG:
        if (q_start == DIAG_RESTART) begin
          if ((q_data[15:8] != 8'h00 && q_data[15:8] != DATA_ON)
              || q_data[7:0] != 8'h00)
            next_sub = SUB_BAD_DATA;
        end else if (q_start == DIAG_LISTEN) begin
          if (q_data != 16'h0000) next_sub = SUB_BAD_DATA;
        end else if (q_start != DIAG_ECHO)
          next_sub = SUB_BAD_ADDR;
      FN_READ_STAT, FN_DEV_TYPE: next_sub = 8'h00;
      FN_SCRATCH:
        if (span > 17'(SP_TOP + 1)) next_sub = SUB_BAD_ADDR;
      default: next_sub = SUB_BAD_FUNC;
    endcase
    if (next_sub == 8'h00 && core_fail)
      next_sub = SUB_FAIL;
  end

  // ********************************************************
  // frame verdict and exception response
  // ********************************************************
  logic [7:0]  resp [RESP_BYTES];
  logic [2:0]  tx_idx;
  logic        sending;
  logic [15:0] crc;
  logic [15:0] next_crc;
  logic        accept;
  // short data is dropped silently; the bad-data answer is left to the core
  assign accept = frame_end && in_frame && crc_ok && !bad_seen
                  && !len_short && !port_quiet && !prog_active;

  always_comb begin
    next_crc = crc ^ {8'h00, tx_byte};
    for (int i = 0; i < 8; i++)
      next_crc = next_crc[0] ? ((next_crc >> 1) ^ CRC_POLY)
                             : (next_crc >> 1);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      frame_ok   <= 1'b0;
      frame_drop <= 1'b0;
      sending    <= 1'b0;
      tx_idx     <= 3'h0;
      tx_valid   <= 1'b0;
      tx_byte    <= 8'h00;
      crc        <= CRC_INIT;
      for (int i = 0; i < RESP_BYTES; i++) resp[i] <= 8'h00;
    end else if (clk_en) begin
      frame_ok   <= accept && next_sub == 8'h00;
      frame_drop <= (frame_end && !accept) || gap_hit;
      if (accept && next_sub != 8'h00 && !sending) begin
        resp[0]  <= q_addr;
        resp[1]  <= q_func + EXC_FLAG;
        resp[2]  <= next_sub;
        sending  <= 1'b1;
        tx_idx   <= 3'h0;
        tx_valid <= 1'b1;
        tx_byte  <= q_addr;
        crc      <= CRC_INIT;
      end else if (sending && tx_valid && tx_ready) begin
        if (tx_idx == 3'(RESP_BYTES - 1)) begin
          sending  <= 1'b0;
          tx_valid <= 1'b0;
        end else begin
          tx_idx <= tx_idx + 3'h1;
          if (tx_idx == 3'h2) begin
            tx_byte <= next_crc[7:0];
            resp[4] <= next_crc[15:8];
          end else if (tx_idx == 3'h3)
            tx_byte <= resp[4];
          else
            tx_byte <= resp[tx_idx + 3'h1];
          crc <= next_crc;
        end
      end
    end
  end

  // ********************************************************
  // protocol switch and idle timeout
  // ********************************************************
  rsp_mode_type mode;
  logic [$clog2(IDLE_CYCLES+1)-1:0] idle_cnt;
  logic cfg_pending;

  always_ff @(posedge mclk) begin
    if (rst) begin
      mode          <= rsp_rtu_type;
      idle_cnt      <= '0;
      cfg_pending   <= 1'b0;
      prog_active   <= 1'b0;
      port_quiet    <= 1'b0;
      apply_new_cfg <= 1'b0;
    end else if (clk_en) begin
      apply_new_cfg <= 1'b0;
      if (new_cfg && mode != rsp_rtu_type) cfg_pending <= 1'b1;
      unique case (mode)
        rsp_rtu_type:
          if (prog_attach) begin
            mode        <= rsp_prog_type;
            prog_active <= 1'b1;
            idle_cnt    <= '0;
          end
        rsp_prog_type: begin
          // blank id and zero turnaround are the partner's side
          if (brk_sync[1]) begin
            idle_cnt <= '0;
          end else if (rx_valid) begin
            idle_cnt <= '0;
          end else if (idle_cnt == ($bits(idle_cnt))'(IDLE_CYCLES - 1)) begin
            mode        <= rsp_drain_type;
            prog_active <= 1'b0;
            port_quiet  <= 1'b1;
          end else
            idle_cnt <= idle_cnt + 1'b1;
        end
        rsp_drain_type: begin
          mode          <= rsp_rtu_type;
          port_quiet    <= 1'b0;
          apply_new_cfg <= cfg_pending || new_cfg;
          cfg_pending   <= 1'b0;
        end
        default: mode <= rsp_rtu_type;
      endcase
    end
  end

  // ********************************************************
  // persistent datagram count
  // ********************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      dg_count   <= 6'h00;
      dg_granted <= 1'b0;
      dg_denied  <= 1'b0;
    end else if (clk_en) begin
      dg_granted <= dg_establish && dg_count < 6'(MAX_DATAGRAMS);
      dg_denied  <= dg_establish && dg_count >= 6'(MAX_DATAGRAMS);
      if (dg_establish && dg_count < 6'(MAX_DATAGRAMS) && !dg_cancel)
        dg_count <= dg_count + 6'h01;
      else if (dg_cancel && !dg_establish && dg_count != 6'h00)
        dg_count <= dg_count - 6'h01;
    end
  end
endmodule

// >>> rsp_checker_props.sv
// concurrent checks on the query checker ports
module rsp_checker_props (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       clk_en,
  input wire logic [7:0] q_addr,
  input wire logic [7:0] q_func,
  input wire logic       prog_attach,
  input wire logic       dg_establish,
  input wire logic       dg_cancel,
  input wire logic       tx_ready,
  input wire logic       tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic       frame_ok,
  input wire logic       frame_drop,
  input wire logic       prog_active,
  input wire logic       port_quiet,
  input wire logic [5:0] dg_count,
  input wire logic       dg_granted,
  input wire logic       dg_denied
);
  import rsp_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ****************************************
  // reply framing, datagram and programming mode checks
  // ****************************************
  sequence s_exc_go;
    $rose(tx_valid) ##0 tx_ready && clk_en;
  endsequence
  sequence s_grant;
    dg_establish && !dg_cancel && clk_en && dg_count < 6'h20;
  endsequence
  a_reset_clear: assert property (disable iff (1'b0)
    rst |=> !tx_valid && !prog_active && dg_count == 6'h00)
    else $error("outputs not cleared by reset");
  a_addr_copy: assert property (
    $rose(tx_valid) |-> tx_byte == $past(q_addr))
    else $error("reply address differs");
  a_func_flag: assert property (
    s_exc_go |=> tx_byte == ($past(q_func, 2) + EXC_FLAG))
    else $error("exception function byte wrong");
  a_tx_hold: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
    else $error("offered byte changed before accept");
  a_drop_quiet: assert property (frame_drop |-> !$rose(tx_valid))
    else $error("dropped frame answered");
  a_ok_quiet: assert property (
    frame_ok |-> !$rose(tx_valid) && !frame_drop)
    else $error("good frame answered or dropped");
  a_dg_grant: assert property (
    s_grant |=> dg_granted && dg_count == $past(dg_count) + 6'h01)
    else $error("establish not granted");
  a_dg_deny: assert property (
    dg_establish && !dg_cancel && clk_en && dg_count == 6'h20
    |=> dg_denied && dg_count == 6'h20)
    else $error("establish past limit not denied");
  a_prog_enter: assert property (
    prog_attach && clk_en && !prog_active && !port_quiet |=> prog_active)
    else $error("programming mode not entered");
  a_quiet_once: assert property (
    port_quiet && clk_en |=> !port_quiet && !prog_active)
    else $error("drain state not left");
endmodule
bind rsp_checker rsp_checker_props rsp_checker_props_i (.mclk, .rst,
  .clk_en, .q_addr, .q_func, .prog_attach, .dg_establish, .dg_cancel,
  .tx_ready, .tx_valid, .tx_byte, .frame_ok, .frame_drop, .prog_active,
  .port_quiet, .dg_count, .dg_granted, .dg_denied);

// >>> rsp_checker_test.sv
// self-checking bench for the query checker
module rsp_checker_test;
  timeunit 1ns;
  timeprecision 1ps;
  import rsp_pkg::*;
  logic        mclk = 1'b0, rst = 1'b1, rx_valid = 1'b0, frame_end = 1'b0;
  logic        crc_ok = 1'b1, len_short = 1'b0, core_fail = 1'b0, slow = 1'b0;
  logic        clk_en = 1'b1, rx_err = 1'b0, rx_break = 1'b0;
  logic        prog_attach = 1'b0, new_cfg = 1'b0, dg_establish = 1'b0;
  logic        dg_cancel = 1'b0, tx_valid, frame_ok, frame_drop, prog_active;
  logic        port_quiet, apply_new_cfg, dg_granted, dg_denied, tx_ready;
  logic [7:0]  q_addr = 8'h11, q_func = 8'h00, tx_byte;
  logic [15:0] q_start = 16'h0000, q_count = 16'h0001, q_data = 16'h0000;
  logic [5:0]  dg_count;
  int          fail_count = 0, tests_run = 0;
  rsp_checker #(.CHAR_CYCLES(4), .IDLE_CYCLES(50)) rsp_checker_i (.mclk,
    .rst, .clk_en, .rx_valid, .rx_byte(q_func), .rx_err,
    .rx_break, .frame_end, .crc_ok, .len_short, .q_addr, .q_func,
    .q_start, .q_count, .q_data, .core_fail, .prog_attach, .new_cfg,
    .dg_establish, .dg_cancel, .tx_ready, .tx_valid, .tx_byte, .frame_ok,
    .frame_drop, .prog_active, .port_quiet, .apply_new_cfg, .dg_granted,
    .dg_denied, .dg_count);
  rsp_master_model rsp_master_model_i (.mclk, .slow, .tx_valid, .tx_byte,
    .tx_ready);
  // ****************************************
  // helpers and scenarios
  // ****************************************
  task automatic cmp(input logic [15:0] got, exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = CRC_INIT;
    foreach (b[i]) begin
      c ^= {8'h00, b[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    return c;
  endfunction
  task automatic pulse(ref logic s);
    @(negedge mclk) s = 1'b1;
    @(negedge mclk) s = 1'b0;
  endtask
  task automatic query(input logic [7:0] fn, input logic [15:0] st, cn, dt);
    @(negedge mclk);
    {q_func, q_start, q_count, q_data, rx_valid} = {fn, st, cn, dt, 1'b1};
    @(negedge mclk) {rx_valid, frame_end} = 2'b01;
    @(negedge mclk) frame_end = 1'b0;
  endtask
  task automatic plain(input logic [7:0] fn, input logic [15:0] st, cn, dt,
                       input logic okv, dropv);
    query(fn, st, cn, dt);
    cmp(frame_ok, okv, "ok");
    cmp({frame_drop, tx_valid}, {dropv, 1'b0}, "drop");
  endtask
  task automatic exc(input logic [7:0] fn, sub, input logic [15:0] st, cn, dt);
    logic [7:0]  e[$];
    logic [15:0] c;
    rsp_master_model_i.got.delete();
    e = '{q_addr, fn + EXC_FLAG, sub};
    c = crc16(e);
    e.push_back(c[7:0]);
    e.push_back(c[15:8]);
    query(fn, st, cn, dt);
    for (int i = 0; i < 40 && rsp_master_model_i.got.size() < 5; i++)
      @(negedge mclk);
    cmp(16'(rsp_master_model_i.got.size()), 16'd5, "length");
    foreach (e[i]) cmp(rsp_master_model_i.got[i], e[i], "byte");
    @(negedge mclk);
  endtask
  task automatic t_func();
    logic [7:0] g[11] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
                          8'h08, 8'h0F, 8'h10, 8'h43};
    foreach (g[i]) plain(g[i], 16'h0000, 16'h0001, 16'h0000, 1'b1, 1'b0);
    plain(FN_DEV_TYPE, 16'h0000, 16'h0001, 16'h0000, 1'b1, 1'b0);
    foreach (g[i]) exc(g[i] + 8'h20, SUB_BAD_FUNC, 0, 1, 0);
  endtask
  task automatic t_addr();
    logic [39:0] t[10] = '{{8'h01, 16'h07FF, 16'h0002},
      {8'h02, 16'h07FF, 16'h0002}, {8'h0F, 16'h07FF, 16'h0002},
      {8'h04, 16'h03FF, 16'h0002}, {8'h10, 16'h03FF, 16'h0002},
      {8'h03, 16'h003F, 16'h0002}, {8'h05, 16'h0800, 16'h0001},
      {8'h06, 16'h0400, 16'h0001}, {8'h08, 16'h0002, 16'h0001},
      {8'h43, 16'h00FF, 16'h0002}};
    plain(FN_READ_OUT, 16'h07FE, 16'h0002, 16'h0000, 1'b1, 1'b0);
    foreach (t[i]) exc(t[i][39:32], SUB_BAD_ADDR, t[i][31:16], t[i][15:0],
                       16'h0000);
  endtask
  task automatic t_data();
    plain(FN_FORCE_ONE, 0, 1, 16'hFF00, 1'b1, 1'b0);
    plain(FN_DIAG, DIAG_RESTART, 1, 16'hFF00, 1'b1, 1'b0);
    exc(FN_FORCE_ONE, SUB_BAD_DATA, 0, 1, 16'h1200);
    exc(FN_DIAG, SUB_BAD_DATA, DIAG_RESTART, 1, 16'h0001);
    exc(FN_DIAG, SUB_BAD_DATA, DIAG_LISTEN, 1, 16'hFF00);
  endtask
  task automatic t_fail_drop();
    core_fail = 1'b1;
    slow = 1'b1;
    exc(FN_READ_AI, SUB_FAIL, 0, 1, 0);
    exc(8'h09, SUB_BAD_FUNC, 0, 1, 0);
    {core_fail, slow, crc_ok} = 3'b000;
    plain(8'h09, 0, 1, 0, 1'b0, 1'b1);
    {crc_ok, len_short} = 2'b11;
    plain(8'h09, 0, 1, 0, 1'b0, 1'b1);
    len_short = 1'b0;
  endtask
  task automatic t_err_freeze();
    rx_err = 1'b1;
    repeat (3) @(negedge mclk);
    rx_err = 1'b0;
    plain(FN_READ_OUT, 0, 1, 0, 1'b0, 1'b1);
    plain(FN_READ_OUT, 0, 1, 0, 1'b1, 1'b0);
    @(negedge mclk) clk_en = 1'b0;
    pulse(dg_establish);
    cmp({dg_granted, dg_count}, {1'b0, 6'h1F}, "freeze");
    plain(FN_READ_OUT, 0, 1, 0, 1'b0, 1'b0);
    clk_en = 1'b1;
  endtask
  task automatic t_gap();
    int n;
    pulse(rx_valid);
    for (n = 0; n < 40 && frame_drop !== 1'b1; n++) @(negedge mclk);
    cmp(16'(n > 12 && n < 20), 16'd1, "gap drop");
    cmp(tx_valid, 1'b0, "gap reply");
  endtask
  task automatic t_prog();
    int n;
    pulse(prog_attach);
    cmp(prog_active, 1'b1, "attach");
    pulse(new_cfg);
    plain(8'h09, 0, 1, 0, 1'b0, 1'b1);
    for (n = 0; n < 80 && port_quiet !== 1'b1; n++) @(negedge mclk);
    cmp(16'(n > 40 && n < 60), 16'd1, "idle span");
    @(negedge mclk);
    cmp({apply_new_cfg, prog_active}, 2'b10, "restore");
    pulse(prog_attach);
    repeat (30) @(negedge mclk);
    pulse(rx_break);
    for (n = 0; n < 80 && port_quiet !== 1'b1; n++) @(negedge mclk);
    cmp(16'(n > 45 && n < 60), 16'd1, "break span");
    @(negedge mclk);
    cmp({apply_new_cfg, prog_active}, 2'b00, "plain restore");
  endtask
  task automatic t_dg();
    cmp(dg_count, 6'h00, "start");
    repeat (32) begin
      pulse(dg_establish);
      cmp(dg_granted, 1'b1, "grant");
    end
    pulse(dg_establish);
    cmp({dg_denied, dg_count}, {1'b1, 6'h20}, "deny");
    @(negedge mclk) {dg_establish, dg_cancel} = 2'b11;
    @(negedge mclk) {dg_establish, dg_cancel} = 2'b00;
    cmp(dg_count, 6'h20, "both");
    pulse(dg_cancel);
    cmp(dg_count, 6'h1F, "cancel");
  endtask
  initial forever #2.5 mclk = ~mclk;
  initial begin
    #100us;
    fail_count++;
    summarize();
  end
  initial begin
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    t_dg();
    t_func();
    t_addr();
    t_data();
    t_fail_drop();
    t_err_freeze();
    t_gap();
    t_prog();
    summarize();
  end
endmodule

// >>> rsp_master_model.sv
// byte sink standing for the master on the reply path
module rsp_master_model (
  input  wire logic       mclk,
  input  wire logic       slow,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_byte,
  output logic            tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got[$];
  logic       tick = 1'b0;
  // slow mode accepts every other cycle to stretch the reply
  always @(posedge mclk) begin
    tick <= !tick;
    if (tx_valid && tx_ready) got.push_back(tx_byte);
  end
  assign tx_ready = !slow || tick;
endmodule

// >>> rsp_pkg.sv
// package: constants for the serial slave query checker
package rsp_pkg;
  localparam logic [7:0] FN_READ_OUT   = 8'h01;
  localparam logic [7:0] FN_READ_IN    = 8'h02;
  localparam logic [7:0] FN_READ_AI    = 8'h03;
  localparam logic [7:0] FN_READ_REG   = 8'h04;
  localparam logic [7:0] FN_FORCE_ONE  = 8'h05;
  localparam logic [7:0] FN_WRITE_ONE  = 8'h06;
  localparam logic [7:0] FN_READ_STAT  = 8'h07;
  localparam logic [7:0] FN_DIAG       = 8'h08;
  localparam logic [7:0] FN_FORCE_MANY = 8'h0F;
  localparam logic [7:0] FN_WRITE_MANY = 8'h10;
  localparam logic [7:0] FN_DEV_TYPE   = 8'h11;
  localparam logic [7:0] FN_SCRATCH    = 8'h43;
  localparam logic [7:0] EXC_FLAG      = 8'h80;
  localparam logic [7:0] SUB_BAD_FUNC  = 8'h01;
  localparam logic [7:0] SUB_BAD_ADDR  = 8'h02;
  localparam logic [7:0] SUB_BAD_DATA  = 8'h03;
  localparam logic [7:0] SUB_FAIL      = 8'h04;
  localparam logic [15:0] DIAG_ECHO    = 16'h0000;
  localparam logic [15:0] DIAG_RESTART = 16'h0001;
  localparam logic [15:0] DIAG_LISTEN  = 16'h0004;
  localparam logic [7:0] DATA_ON       = 8'hFF;
  localparam logic [15:0] CRC_INIT     = 16'hFFFF;
  localparam logic [15:0] CRC_POLY     = 16'hA001;
  localparam int CLK_HZ                = 200_000_000;
  localparam int GAP_CHARS             = 4;
  localparam int IDLE_TIMEOUT_S        = 10;
  localparam int TURNAROUND_MS         = 0;
  localparam int MAX_DATAGRAMS         = 32;
  localparam int RESP_BYTES            = 5;
  localparam int QUERY_BYTES           = 6;
  typedef enum logic [1:0] {rsp_rtu_type, rsp_prog_type, rsp_drain_type}
    rsp_mode_type;
endpackage
